/* File: include/dcsw_cfg.svh */
// Purpose: Constants for the drive control/status word block
// Assumes: 16-bit cyclic control and status words, one clock
// Notes: Bit positions, codes and reset values
// Operation
// - Words exchanged every cycle, readable back
// - Control bits 0-2 are handshake only
// - Control bits 3-5 select block element
// - Control bits 6-7 drive configured processes
// - Control bits 8-9 select operation mode
// - Bit 13 falling halts homing, keeps pending
// - Bit 13 rising resumes homing, else ignored
// - Bit 14 low forces power stage off
// - Bit 15 falling quick-stops, then power off
// - Bit 15 rising with 14 enables stage
// - Stage off engages brake, stops transistors
// - Stage on releases brake, runs mode
// - Status bits 0-2 answer handshake
// - Status bit 5 marks command state change
// - Status bits 6-7 from configured sources
// - Status bits 8-9 report mode in force
// - Bits 11-13 report diagnostic changes, shutdown
// - Bits 14-15 report readiness level
// - First enable edge starts position identification if axis needs it
// - No ready-to-operate until identification succeeds
// - Torque limit unset means no torque
// - Reset request acts at phase zero entry
// - Enable-blocking word zero means enable allowed
`ifndef DCSW_CFG_SVH
`define DCSW_CFG_SVH
`define DCSW_CW_HS_LSB     4'h0
`define DCSW_CW_ELEM_LSB   4'h3
`define DCSW_CW_RT1        4'h6
`define DCSW_CW_RT2        4'h7
`define DCSW_CW_MODE_LSB   4'h8
`define DCSW_CW_HALT       4'hD
`define DCSW_CW_ENABLE     4'hE
`define DCSW_CW_DRIVE_ON   4'hF
`define DCSW_SW_CMD_CHG    4'h5
`define DCSW_SW_C3D        4'hB
`define DCSW_SW_C2D        4'hC
`define DCSW_SW_C1D        4'hD
`define DCSW_RDY_NOT       2'h0
`define DCSW_RDY_MAINS     2'h1
`define DCSW_RDY_POWERED   2'h2
`define DCSW_RDY_ACTIVE    2'h3
`define DCSW_CW_RESET      16'h0000
`define DCSW_BLOCK_CLEAR   32'h00000000
`define DCSW_ELEM_INACTIVE 3'h0
`endif

/* File: include/dcsw_pkg.sv */
// Purpose: Types for the drive control/status word block
// Assumes: Used with dcsw_cfg.svh constants
// Notes: Holds state and mode enums plus state and output structs
package dcsw_pkg;
	typedef enum logic [1:0] {
		DCSW_MODE_PRIMARY,
		DCSW_MODE_SEC1,
		DCSW_MODE_SEC2,
		DCSW_MODE_SEC3
	} dcsw_mode_t;

	typedef enum logic [2:0] {
		DCSW_PS_OFF,
		DCSW_PS_IDENT,
		DCSW_PS_ON,
		DCSW_PS_QSTOP
	} dcsw_ps_t;

	typedef struct packed {
		logic [15:0] cw;
		logic [15:0] cw_prev;
		dcsw_ps_t    ps;
		logic        ident_done;
		logic        homing_halted;
		logic        cmd_chg;
		logic        c3d;
		logic        c2d;
		logic        reset_armed;
	} dcsw_state_t;

	typedef struct packed {
		logic        ps_on;
		logic        brake_rel;
		logic        torque_en;
		logic        qstop;
		logic        ident_start;
		logic        homing_halt;
		logic        homing_resume;
		logic        drive_reset;
		logic [15:0] sw;
	} dcsw_out_t;
endpackage : dcsw_pkg

/* File: hdl/dcsw_edge.sv */
// Purpose: Edge detector for control word bits
// Assumes: Previous word is registered by the caller
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module dcsw_edge (
	input  wire logic [15:0] i_cur,   // Current word
	input  wire logic [15:0] i_prev,  // Word of previous cycle
	output logic      [15:0] o_rise,  // Zero to one per bit
	output logic      [15:0] o_fall   // One to zero per bit
);
	// Per-bit transitions
	always_comb begin
		o_rise = i_cur & ~i_prev;
		o_fall = ~i_cur & i_prev;
	end
endmodule : dcsw_edge
`default_nettype wire

/* File: hdl/dcsw_core.sv */
// Purpose: Decode master control word, build drive status word
// Assumes: One new control word per I_CW_VALID pulse
// Notes: Motion loops and channel transport live outside
`timescale 1ns/1ps
`default_nettype none
`include "dcsw_cfg.svh"
module dcsw_core (
	input  wire logic        I_MCLK,          // 20 MHz clock
	input  wire logic        I_RST,           // Async reset, high
	input  wire logic        I_CW_VALID,      // Control word strobe
	input  wire logic [15:0] I_CW,            // Control word from master
	input  wire logic [2:0]  I_SC_HS,         // Drive handshake answer
	input  wire logic        I_RT_STAT1,      // Realtime status source 1
	input  wire logic        I_RT_STAT2,      // Realtime status source 2
	input  wire logic        I_CMD_EVENT,     // Procedure command changed
	input  wire logic        I_CMD_ACK,       // Clear command change flag
	input  wire logic        I_C3D_EVENT,     // Class-3 diagnostic change
	input  wire logic        I_C2D_EVENT,     // Class-2 diagnostic change
	input  wire logic        I_DIAG_ACK,      // Clear diagnostic flags
	input  wire logic        I_C1D_ERROR,     // Class-1 shutdown active
	input  wire logic        I_MAINS_READY,   // Ready for main power
	input  wire logic        I_MAINS_ON,      // Main power applied
	input  wire logic        I_NEEDS_IDENT,   // Axis needs identification
	input  wire logic        I_IDENT_OK,      // Identification finished
	input  wire logic        I_HOMING,        // Drive-controlled homing running
	input  wire logic        I_STOPPED,       // Motor at standstill
	input  wire logic        I_TORQUE_SET,    // Torque limit set in phase 2
	input  wire logic        I_RESET_REQ,     // Reset-on-phase-zero request
	input  wire logic        I_PHASE0_ENTER,  // Entering phase 0 pulse
	input  wire logic [31:0] I_BLOCK_SRC,     // Enable blocking reasons
	output logic      [15:0] O_SW,            // Status word to master
	output logic      [15:0] O_CW_READ,       // Control word readback
	output logic      [15:0] O_SW_READ,       // Status word readback
	output logic      [31:0] O_BLOCK,         // Enable blocking word
	output logic      [2:0]  O_SC_HS_M,       // Master handshake bits
	output logic      [2:0]  O_SC_ELEM,       // Selected block element
	output logic             O_SC_ACTIVE,     // Service channel active
	output logic             O_RT_CTRL1,      // Realtime control bit 1
	output logic             O_RT_CTRL2,      // Realtime control bit 2
	output logic      [1:0]  O_MODE,          // Mode in force
	output logic             O_PS_ON,         // Power stage transistors on
	output logic             O_BRAKE_REL,     // Holding brake released
	output logic             O_TORQUE_EN,     // Torque may be delivered
	output logic             O_QSTOP,         // Quick-stop deceleration
	output logic             O_IDENT_START,   // Identification start pulse
	output logic             O_HOMING_HALT,   // Halt homing, keep pending
	output logic             O_HOMING_RESUME, // Resume homing pulse
	output logic             O_DRIVE_RESET    // Drive reset pulse
);
	dcsw_pkg::dcsw_state_t st;       // Registered state
	dcsw_pkg::dcsw_state_t next_st;  // Next state
	dcsw_pkg::dcsw_out_t   ob;       // Registered outputs
	dcsw_pkg::dcsw_out_t   next_ob;  // Next outputs
	logic [15:0]           rise;     // Control rising edges
	logic [15:0]           fall;     // Control falling edges

	// Edges between successive control words
	dcsw_edge u_edge (
		.i_cur  (st.cw),
		.i_prev (st.cw_prev),
		.o_rise (rise),
		.o_fall (fall)
	);

	// Readiness code from state and power inputs
	function automatic logic [1:0] ready_code(
		input dcsw_pkg::dcsw_ps_t ps,
		input logic               c1d,
		input logic               mains_rdy,
		input logic               mains_on
	);
		logic [1:0] r;
		r = `DCSW_RDY_NOT;
		if (c1d || !mains_rdy) begin
			r = `DCSW_RDY_NOT;
		end else if (ps == dcsw_pkg::DCSW_PS_ON && mains_on) begin
			r = `DCSW_RDY_ACTIVE;
		end else if (mains_on) begin
			r = `DCSW_RDY_POWERED;
		end else begin
			r = `DCSW_RDY_MAINS;
		end
		return r;
	endfunction : ready_code

	// Next state and next outputs
	always_comb begin
		next_st = st;
		next_ob = ob;
		next_ob.ident_start   = 1'b0;
		next_ob.homing_resume = 1'b0;
		next_ob.drive_reset   = 1'b0;
		next_st.cw_prev = st.cw;
		// Capture a new word; edges seen next cycle
		if (I_CW_VALID) begin
			next_st.cw = I_CW;
		end
		// Halt and restart apply only during homing
		if (I_HOMING) begin
			if (fall[`DCSW_CW_HALT]) begin
				next_st.homing_halted = 1'b1;
			end else if (rise[`DCSW_CW_HALT] && st.homing_halted) begin
				next_st.homing_halted = 1'b0;
				next_ob.homing_resume = 1'b1;
			end
		end else begin
			next_st.homing_halted = 1'b0;
		end
		// Power stage sequencing
		case (st.ps)
			dcsw_pkg::DCSW_PS_OFF: begin
				if (rise[`DCSW_CW_DRIVE_ON] && st.cw[`DCSW_CW_ENABLE] && !I_C1D_ERROR
					&& I_BLOCK_SRC == `DCSW_BLOCK_CLEAR) begin
					if (I_NEEDS_IDENT && !st.ident_done) begin
						next_st.ps = dcsw_pkg::DCSW_PS_IDENT;
						next_ob.ident_start = 1'b1;
					end else begin
						next_st.ps = dcsw_pkg::DCSW_PS_ON;
					end
				end
			end
			dcsw_pkg::DCSW_PS_IDENT: begin
				if (!st.cw[`DCSW_CW_ENABLE] || I_C1D_ERROR) begin
					next_st.ps = dcsw_pkg::DCSW_PS_OFF;
				end else if (fall[`DCSW_CW_DRIVE_ON]) begin
					next_st.ps = dcsw_pkg::DCSW_PS_QSTOP;
				end else if (I_IDENT_OK) begin
					next_st.ident_done = 1'b1;
					next_st.ps = dcsw_pkg::DCSW_PS_ON;
				end
			end
			dcsw_pkg::DCSW_PS_ON: begin
				if (!st.cw[`DCSW_CW_ENABLE] || I_C1D_ERROR) begin
					next_st.ps = dcsw_pkg::DCSW_PS_OFF;
				end else if (fall[`DCSW_CW_DRIVE_ON]) begin
					next_st.ps = dcsw_pkg::DCSW_PS_QSTOP;
				end
			end
			dcsw_pkg::DCSW_PS_QSTOP: begin
				if (!st.cw[`DCSW_CW_ENABLE] || I_C1D_ERROR || I_STOPPED) begin
					next_st.ps = dcsw_pkg::DCSW_PS_OFF;
				end
			end
			default: begin
				next_st.ps = dcsw_pkg::DCSW_PS_OFF;
			end
		endcase
		// Stage drive, brake and torque follow the next state
		next_ob.ps_on     = next_st.ps != dcsw_pkg::DCSW_PS_OFF;
		next_ob.brake_rel = next_ob.ps_on;
		next_ob.torque_en = next_ob.ps_on && I_TORQUE_SET;
		next_ob.qstop     = next_st.ps == dcsw_pkg::DCSW_PS_QSTOP;
		next_ob.homing_halt = next_st.homing_halted;
		// Sticky change flags, event wins over clear
		if (I_CMD_EVENT) begin
			next_st.cmd_chg = 1'b1;
		end else if (I_CMD_ACK) begin
			next_st.cmd_chg = 1'b0;
		end
		if (I_C3D_EVENT) begin
			next_st.c3d = 1'b1;
		end else if (I_DIAG_ACK) begin
			next_st.c3d = 1'b0;
		end
		if (I_C2D_EVENT) begin
			next_st.c2d = 1'b1;
		end else if (I_DIAG_ACK) begin
			next_st.c2d = 1'b0;
		end
		// Reset request acts at phase zero entry, remembered one cycle only
		if (I_PHASE0_ENTER && (st.reset_armed || I_RESET_REQ)) begin
			next_ob.drive_reset = 1'b1;
			next_st.reset_armed = 1'b0;
		end else begin
			next_st.reset_armed = I_RESET_REQ;
		end
		// Status word assembly, reserved bits zero
		next_ob.sw = 16'h0000;
		next_ob.sw[2:0] = I_SC_HS;
		next_ob.sw[`DCSW_SW_CMD_CHG] = next_st.cmd_chg;
		next_ob.sw[6] = I_RT_STAT1;
		next_ob.sw[7] = I_RT_STAT2;
		next_ob.sw[9:8] = next_ob.ps_on ? st.cw[9:8] : ob.sw[9:8];
		next_ob.sw[`DCSW_SW_C3D] = next_st.c3d;
		next_ob.sw[`DCSW_SW_C2D] = next_st.c2d;
		next_ob.sw[`DCSW_SW_C1D] = I_C1D_ERROR;
		next_ob.sw[15:14] = ready_code(next_st.ps, I_C1D_ERROR, I_MAINS_READY, I_MAINS_ON);
	end

	// State and output registers
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			st <= '{cw: `DCSW_CW_RESET, cw_prev: `DCSW_CW_RESET, ps: dcsw_pkg::DCSW_PS_OFF, default: 1'b0};
			ob <= '{sw: 16'h0000, default: 1'b0};
		end else begin
			st <= next_st;
			ob <= next_ob;
		end
	end

	// Readback and decoded-field registers
	logic [15:0] sw_rd;       // Status readback
	logic [31:0] block_q;     // Blocking word
	logic [15:0] cw_q;        // Decoded control copy
	logic        sc_act;      // Channel active flag, registered so the pin has no decode glitch
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			sw_rd   <= 16'h0000;
			block_q <= `DCSW_BLOCK_CLEAR;
			cw_q    <= `DCSW_CW_RESET;
			sc_act  <= 1'b0;
		end else begin
			sw_rd   <= next_ob.sw;
			block_q <= I_BLOCK_SRC;
			cw_q    <= next_st.cw & 16'hE3FF;
			sc_act  <= next_st.cw[5:3] != `DCSW_ELEM_INACTIVE;
		end
	end

	// Output wiring, all from flip-flops
	always_comb begin
		O_SW            = ob.sw;
		O_SW_READ       = sw_rd;
		O_CW_READ       = st.cw;
		O_BLOCK         = block_q;
		O_SC_HS_M       = cw_q[2:0];
		O_SC_ELEM       = cw_q[5:3];
		O_SC_ACTIVE     = sc_act;
		O_RT_CTRL1      = cw_q[`DCSW_CW_RT1];
		O_RT_CTRL2      = cw_q[`DCSW_CW_RT2];
		O_MODE          = ob.sw[9:8];
		O_PS_ON         = ob.ps_on;
		O_BRAKE_REL     = ob.brake_rel;
		O_TORQUE_EN     = ob.torque_en;
		O_QSTOP         = ob.qstop;
		O_IDENT_START   = ob.ident_start;
		O_HOMING_HALT   = ob.homing_halt;
		O_HOMING_RESUME = ob.homing_resume;
		O_DRIVE_RESET   = ob.drive_reset;
	end
endmodule : dcsw_core
`default_nettype wire

/* File: tb/dcsw_monitor.sv */
// Purpose: Port checks for the control and status word block
// Assumes: Bound to dcsw_core, one clock domain
// Notes: Latencies follow the hand-over timing
`timescale 1ns/1ps
`default_nettype none
module dcsw_monitor (
	input wire logic        I_MCLK,       // Block clock
	input wire logic        I_RST,        // Async reset, high
	input wire logic        I_CW_VALID,   // Word strobe
	input wire logic [15:0] I_CW,         // Word from master
	input wire logic        I_C1D_ERROR,  // Shutdown error level
	input wire logic        I_TORQUE_SET, // Torque limit set
	input wire logic [15:0] O_SW,         // Status word
	input wire logic [15:0] O_SW_READ,    // Status readback
	input wire logic [15:0] O_CW_READ,    // Control readback
	input wire logic [2:0]  O_SC_ELEM,    // Element field
	input wire logic        O_SC_ACTIVE,  // Channel active
	input wire logic        O_PS_ON,      // Stage on
	input wire logic        O_BRAKE_REL,  // Brake released
	input wire logic        O_QSTOP,      // Quick stop
	input wire logic        O_TORQUE_EN   // Torque allowed
);
	// All checks on the one clock, idle in reset
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// Steps the checks are built from
	sequence s_take; I_CW_VALID; endsequence
	sequence s_no_enable; !O_CW_READ[14]; endsequence
	sequence s_c1d_held; I_C1D_ERROR ##1 I_C1D_ERROR; endsequence
	sequence s_torque_unset; !I_TORQUE_SET ##1 !I_TORQUE_SET; endsequence
	chk_cw_readback: assert property (s_take |=> O_CW_READ == $past(I_CW))
		else $error("control word readback wrong");
	chk_sw_copy: assert property (O_SW_READ == O_SW)
		else $error("status readback differs from status word");
	chk_elem_field: assert property (s_take |=> O_SC_ELEM == $past(I_CW[5:3]) && O_SC_ACTIVE == (O_SC_ELEM != 3'h0))
		else $error("element field wrong");
	chk_stage_needs_en: assert property (s_no_enable |=> !O_PS_ON)
		else $error("stage on without enable bit");
	chk_brake_tie: assert property (O_BRAKE_REL == O_PS_ON)
		else $error("brake not tied to stage");
	chk_qstop_stage: assert property (O_QSTOP |-> O_PS_ON)
		else $error("quick stop with stage off");
	chk_reserved_zero: assert property (O_SW[4:3] == 2'h0 && !O_SW[10])
		else $error("reserved status bit set");
	chk_ready_active: assert property (O_SW[15:14] == 2'h3 |-> O_PS_ON)
		else $error("ready to operate with stage off");
	chk_c1d_shutdown: assert property (s_c1d_held |-> O_SW[13] && !O_PS_ON && O_SW[15:14] == 2'h0)
		else $error("shutdown not reported");
	chk_torque_gate: assert property (s_torque_unset |-> !O_TORQUE_EN)
		else $error("torque without limit set");
endmodule : dcsw_monitor
`default_nettype wire

/* File: tb/dcsw_master_model.sv */
// Purpose: Cyclic master sending one control word per cycle
// Assumes: Bench chooses the word to send
// Notes: Check input may be cleared to enable against a block
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model (
	input  wire logic        i_clk,   // Bus clock
	input  wire logic        i_rst,   // Async reset, high
	input  wire logic [15:0] i_word,  // Word to send next
	input  wire logic [31:0] i_block, // Enable blocking word read back
	input  wire logic        i_check, // Honour the blocking word
	output logic             o_valid, // Word strobe
	output logic      [15:0] o_cw     // Word on the bus
);
	// New word each cycle, drive-on withheld while blocked
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_cw    <= 16'h0000;
		end else begin
			o_valid <= 1'b1;
			o_cw    <= (i_check && i_block != 32'h0) ? (i_word & 16'h7FFF) : i_word;
		end
	end
endmodule : dcsw_master_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the control and status word block
// Assumes: Master model sends one word per cycle
// Notes: Checks read outputs settled from the previous edge
`timescale 1ns/1ps
`default_nettype none
bind dcsw_core dcsw_monitor mon_u (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CW_VALID(I_CW_VALID), .I_CW(I_CW),
	.I_C1D_ERROR(I_C1D_ERROR), .I_TORQUE_SET(I_TORQUE_SET), .O_SW(O_SW), .O_SW_READ(O_SW_READ),
	.O_CW_READ(O_CW_READ), .O_SC_ELEM(O_SC_ELEM), .O_SC_ACTIVE(O_SC_ACTIVE), .O_PS_ON(O_PS_ON),
	.O_BRAKE_REL(O_BRAKE_REL), .O_QSTOP(O_QSTOP), .O_TORQUE_EN(O_TORQUE_EN));
`define CHK(NM, EX, AC) begin n_checks++; if ((AC) !== (EX)) begin bad_count++; \
	$display("mismatch %s exp %0h seen %0h", NM, EX, AC); end end
module tb_top;
	logic        clk = 1'b0, rst = 1'b1, clr = 1'b0, chk_blk = 1'b1, vld;
	logic        rt1, rt2, cev, cack, c3, c2, dack, c1d, mrdy, mon, nid, iok, hom, stp, tqs, rreq, p0;
	logic [15:0] word = 16'h0000, cw, sw, cwr, swr;
	logic [31:0] bsrc = 32'h00000000, blk;
	logic [2:0]  sc_hs = 3'h0, hsm, elem, seen = 3'h0;
	logic [1:0]  mode;
	logic        act, rc1, rc2, pson, brk, tqe, qs, ids, hh, hr, drs;
	int          bad_count = 0, n_checks = 0;
	dcsw_master_model mst_u (.i_clk(clk), .i_rst(rst), .i_word(word), .i_block(blk), .i_check(chk_blk),
		.o_valid(vld), .o_cw(cw));
	dcsw_core dut_u (.I_MCLK(clk), .I_RST(rst), .I_CW_VALID(vld), .I_CW(cw), .I_SC_HS(sc_hs),
		.I_RT_STAT1(rt1), .I_RT_STAT2(rt2), .I_CMD_EVENT(cev), .I_CMD_ACK(cack), .I_C3D_EVENT(c3),
		.I_C2D_EVENT(c2), .I_DIAG_ACK(dack), .I_C1D_ERROR(c1d), .I_MAINS_READY(mrdy), .I_MAINS_ON(mon),
		.I_NEEDS_IDENT(nid), .I_IDENT_OK(iok), .I_HOMING(hom), .I_STOPPED(stp), .I_TORQUE_SET(tqs),
		.I_RESET_REQ(rreq), .I_PHASE0_ENTER(p0), .I_BLOCK_SRC(bsrc), .O_SW(sw), .O_CW_READ(cwr),
		.O_SW_READ(swr), .O_BLOCK(blk), .O_SC_HS_M(hsm), .O_SC_ELEM(elem), .O_SC_ACTIVE(act),
		.O_RT_CTRL1(rc1), .O_RT_CTRL2(rc2), .O_MODE(mode), .O_PS_ON(pson), .O_BRAKE_REL(brk),
		.O_TORQUE_EN(tqe), .O_QSTOP(qs), .O_IDENT_START(ids), .O_HOMING_HALT(hh),
		.O_HOMING_RESUME(hr), .O_DRIVE_RESET(drs));
	// Half period of the 20 MHz clock
	always #25 clk = ~clk;
	// Sticky capture of one-cycle pulses
	always @(posedge clk) seen <= (clr || rst) ? 3'h0 : (seen | {drs, hr, ids});
	// Readiness expected from the level inputs
	function automatic logic [1:0] rdy(input logic on);
		return (c1d | !mrdy) ? 2'h0 : (on & mon) ? 2'h3 : {mon, !mon};
	endfunction : rdy
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// Send a word, give it time to pass the edge detector
	task automatic put(input logic [15:0] w);
		word <= w;
		wt(5);
	endtask : put
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	// Main sequence
	initial begin
		logic [31:0] r;
		logic [15:0] w;
		{rt1, rt2, cev, cack, c3, c2, dack, c1d, mrdy, mon, nid, iok, hom, stp, tqs, rreq, p0} <= 17'h0;
		void'($urandom(32'h6d301611));
		wt(20);
		rst <= 1'b0;
		wt(1);
		`CHK("reset sw", 16'h0000, sw)
		for (int e = 0; e < 8; e++) begin
			r = $urandom;
			{sc_hs, rt1, rt2, mrdy, mon} <= {r[2:0], r[3], r[4], r[20], r[21]};
			w = {3'h0, r[12:6], e[2:0], r[15:13]};
			put(w);
			`CHK("cw readback", w, cwr)
			`CHK("sw readback", sw, swr)
			`CHK("master hs", w[2:0], hsm)
			`CHK("element", e[2:0], elem)
			`CHK("active", e != 0, act)
			`CHK("rt control", w[7:6], {rc2, rc1})
			`CHK("hs answer", r[2:0], sw[2:0])
			`CHK("rt status", {r[4], r[3]}, sw[7:6])
			`CHK("mode held", 2'h0, sw[9:8])
			`CHK("ready", rdy(1'b0), sw[15:14])
		end
		$display("test fields done");
		{mrdy, mon, tqs, nid} <= 4'hF;
		put(16'h4000);
		put(16'hC100);
		`CHK("ident start", 1'b1, seen[0])
		`CHK("ident ready", 2'h2, sw[15:14])
		iok <= 1'b1;
		wt(4);
		`CHK("ident done", rdy(1'b1), sw[15:14])
		for (int m = 0; m < 4; m++) begin
			put({6'h30, m[1:0], 8'h00});
			`CHK("mode", m[1:0], mode)
			`CHK("mode report", m[1:0], sw[9:8])
			`CHK("brake", 1'b1, brk)
		end
		tqs <= 1'b0;
		wt(3);
		`CHK("torque off", 1'b0, tqe)
		tqs <= 1'b1;
		wt(3);
		`CHK("torque on", 1'b1, tqe)
		$display("test enable done");
		hom <= 1'b1;
		put(16'hE000);
		put(16'hC000);
		`CHK("halted", 2'h3, {hh, pson})
		clr <= 1'b1;
		wt(1);
		clr <= 1'b0;
		put(16'hE000);
		`CHK("resumed", 2'h2, {seen[1], hh})
		hom <= 1'b0;
		put(16'hC000);
		`CHK("halt ignored", 1'b0, hh)
		$display("test homing done");
		put(16'h4000);
		`CHK("quick stop", 2'h3, {qs, pson})
		stp <= 1'b1;
		wt(3);
		`CHK("stopped off", 3'h0, {qs, pson, brk})
		put(16'hC000);
		`CHK("enabled", 1'b1, pson)
		put(16'h8000);
		`CHK("enable dropped", 1'b0, pson)
		put(16'h0000);
		put(16'h8000);
		`CHK("rise refused", 1'b0, pson)
		bsrc <= $urandom | 32'h1;
		chk_blk <= 1'b0;
		put(16'h4000);
		put(16'hC000);
		`CHK("blocked", 1'b0, pson)
		`CHK("block word", bsrc, blk)
		{bsrc, chk_blk} <= {32'h0, 1'b1};
		$display("test stage done");
		{cev, c3, c2} <= 3'h7;
		wt(1);
		{cev, c3, c2} <= 3'h0;
		wt(3);
		`CHK("cmd change", 1'b1, sw[5])
		`CHK("diag change", 2'h3, sw[12:11])
		{cack, dack} <= 2'h3;
		wt(1);
		{cack, dack} <= 2'h0;
		wt(3);
		`CHK("flags cleared", 3'h0, {sw[12:11], sw[5]})
		c1d <= 1'b1;
		wt(3);
		`CHK("shutdown", 3'h4, {sw[13], sw[15:14]})
		{c1d, rreq, clr} <= 3'h3;
		wt(1);
		{clr, p0} <= 2'h1;
		wt(1);
		{p0, rreq} <= 2'h0;
		wt(3);
		`CHK("drive reset", 1'b1, seen[2])
		$display("test status done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
